//--- hdl/qdbr_deadline_mon.sv
`timescale 1ns/1ps
`default_nettype none

module qdbr_deadline_mon (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       wr_strict_i,
  input  wire logic       rd_strict_i,
  input  wire logic       done_i,
  input  wire logic       is_write_i,
  input  wire logic [1:0] priority_class_i,
  input  wire logic       late_i,
  output logic            abort_all_o
);

  // ----------------------------------------------------------------
  // late isochronous completion under the strict flag of its direction aborts everything
  // ----------------------------------------------------------------
  logic isoch;
  logic strict;

  assign isoch  = (priority_class_i == qdbr_pkg::PRIORITY_CLASS_ISOCH);
  assign strict = is_write_i ? wr_strict_i : rd_strict_i;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      abort_all_o <= 1'b0;
    end else begin
      abort_all_o <= done_i & late_i & isoch & strict;
    end
  end

endmodule

`default_nettype wire

//--- hdl/qdbr_pkg.sv
package qdbr_pkg;

  // ----------------------------------------------------------------
  // command codes and field encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_QUEUE_MGMT  = 8'h63;
  localparam logic [7:0] CMD_READ_BUFFER = 8'hE4;
  localparam logic [3:0] SUB_DEADLINE    = 4'h1;
  localparam logic [1:0] PRIORITY_CLASS_ISOCH      = 2'h1;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_CMD  = 12'h000;
  localparam logic [11:0] OFF_CFG  = 12'h004;
  localparam logic [11:0] OFF_STAT = 12'h008;
  localparam logic [11:0] OFF_DATA = 12'h00C;
  localparam logic [11:0] OFF_SDB  = 12'h010;

  // ----------------------------------------------------------------
  // command block word layout
  // ----------------------------------------------------------------
  localparam int CMD_CODE_LSB  = 0;
  localparam int CMD_FEAT_LSB  = 8;
  localparam int CMD_COUNT_LSB = 16;
  localparam int CMD_NUM_LSB   = 24;

  // ----------------------------------------------------------------
  // feature and tag fields
  // ----------------------------------------------------------------
  localparam int FEAT_SUB_LSB       = 0;
  localparam int FEAT_WR_STRICT_BIT = 4;
  localparam int FEAT_RD_STRICT_BIT = 5;
  localparam int FEAT_RSVD_LSB      = 6;
  localparam int TAG_LSB            = 3;

  // ----------------------------------------------------------------
  // status, error and config bit positions
  // ----------------------------------------------------------------
  localparam int STAT_BUSY  = 7;
  localparam int STAT_RDY   = 6;
  localparam int STAT_FAULT = 5;
  localparam int STAT_SEEK  = 4;
  localparam int STAT_DRQ   = 3;
  localparam int STAT_ERR   = 0;
  localparam int ERR_ABT    = 2;
  localparam int STAT_ERRREG_LSB = 8;
  localparam int STAT_WR_STRICT  = 16;
  localparam int STAT_RD_STRICT  = 17;
  localparam int STAT_MISS       = 24;
  localparam int CFG_NCQ_EN_BIT  = 0;
  localparam int CFG_DEPTH_LSB   = 8;

  // ----------------------------------------------------------------
  // reset values and sizes
  // ----------------------------------------------------------------
  localparam logic        NCQ_EN_RST    = 1'b1;
  localparam logic [4:0]  MAX_DEPTH_RST = 5'h1F;
  localparam int          SECTOR_WORDS  = 256;
  localparam int          TAG_W         = 5;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_XFER
  } qdbr_state_type;

endpackage

//--- hdl/qdbr_sector_buf.sv
`timescale 1ns/1ps
`default_nettype none

module qdbr_sector_buf #(
  parameter int WORDS = 256,
  parameter int AW    = 8
) (
  input  wire logic          sys_clk_i,
  input  wire logic          wr_en_i,
  input  wire logic [AW-1:0] wr_addr_i,
  input  wire logic [15:0]   wr_data_i,
  input  wire logic [AW-1:0] rd_addr_i,
  output logic      [15:0]   rd_data_o
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  generate
    if ((1 << AW) != WORDS) begin : g_bad
      $error("sector buffer depth must equal two to the address width");
    end
  endgenerate

  logic [15:0] mem [WORDS];

  always_ff @(posedge sys_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  assign rd_data_o = mem[rd_addr_i];

endmodule

`default_nettype wire

//--- hdl/qdbr_top.sv
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module qdbr_top #(
  parameter int SECTOR_WORDS = qdbr_pkg::SECTOR_WORDS
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        qcmd_done_i,
  input  wire logic        qcmd_is_write_i,
  input  wire logic [1:0]  qcmd_priority_class_i,
  input  wire logic        qcmd_late_i,
  output logic             sdb_fis_o,
  output logic      [4:0]  sdb_tag_o,
  output logic             abort_all_o
);

  localparam int AW = $clog2(SECTOR_WORDS);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  generate
    if (SECTOR_WORDS < 2 || (1 << AW) != SECTOR_WORDS) begin : g_bad_words
      $error("sector word count must be a power of two of at least two");
    end
  endgenerate

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] tag_of(input logic [7:0] field);
    tag_of = field[qdbr_pkg::TAG_LSB +: qdbr_pkg::TAG_W];
  endfunction

  function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] off);
    addr_hit = (addr == off);
  endfunction

  // ----------------------------------------------------------------
  // bus phases
  // ----------------------------------------------------------------
  logic setup_ph;
  logic access_ph;
  logic wr_acc;
  logic rd_acc;
  logic mapped;

  assign setup_ph  = psel_i & ~penable_i;
  assign access_ph = psel_i & penable_i;
  assign wr_acc    = access_ph & pwrite_i;
  assign rd_acc    = access_ph & ~pwrite_i;
  assign mapped    = addr_hit(paddr_i, qdbr_pkg::OFF_CMD)  |
                     addr_hit(paddr_i, qdbr_pkg::OFF_CFG)  |
                     addr_hit(paddr_i, qdbr_pkg::OFF_STAT) |
                     addr_hit(paddr_i, qdbr_pkg::OFF_DATA) |
                     addr_hit(paddr_i, qdbr_pkg::OFF_SDB);

  assign pready_o  = access_ph;
  assign pslverr_o = access_ph & ~mapped;

  // ----------------------------------------------------------------
  // state and registers
  // ----------------------------------------------------------------
  qdbr_pkg::qdbr_state_type state_r;
  logic [7:0]    cmd_code_r;
  logic [7:0]    feat_r;
  logic [7:0]    count_r;
  logic [7:0]    num_r;
  logic          ncq_en_r;
  logic [4:0]    max_depth_r;
  logic          busy_r;
  logic          drq_r;
  logic          err_r;
  logic          abt_r;
  logic          wr_strict_r;
  logic          rd_strict_r;
  logic          miss_r;
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [31:0]   prdata_r;
  logic          sdb_fis_r;
  logic [4:0]    sdb_tag_r;
  logic [15:0]   buf_rd_data;
  logic          abort_all;

  logic cmd_wr;
  logic cfg_wr;
  logic stat_wr;
  logic data_wr;
  logic data_pop;

  assign cmd_wr   = wr_acc & addr_hit(paddr_i, qdbr_pkg::OFF_CMD) & (state_r == qdbr_pkg::ST_IDLE);
  assign cfg_wr   = wr_acc & addr_hit(paddr_i, qdbr_pkg::OFF_CFG);
  assign stat_wr  = wr_acc & addr_hit(paddr_i, qdbr_pkg::OFF_STAT);
  assign data_wr  = wr_acc & addr_hit(paddr_i, qdbr_pkg::OFF_DATA) &
                    (state_r == qdbr_pkg::ST_IDLE);
  assign data_pop = rd_acc & addr_hit(paddr_i, qdbr_pkg::OFF_DATA) &
                    (state_r == qdbr_pkg::ST_XFER);

  // ----------------------------------------------------------------
  // decode of the latched command block
  // ----------------------------------------------------------------
  logic is_qmgmt;
  logic is_deadline;
  logic is_rdbuf;
  logic bad_param;
  logic tag_clash;
  logic tag_invalid;
  logic dl_ok;

  assign is_qmgmt    = (cmd_code_r == qdbr_pkg::CMD_QUEUE_MGMT);
  assign is_deadline = is_qmgmt &
                       (feat_r[qdbr_pkg::FEAT_SUB_LSB +: 4] == qdbr_pkg::SUB_DEADLINE);
  assign is_rdbuf    = (cmd_code_r == qdbr_pkg::CMD_READ_BUFFER);
  assign bad_param   = (feat_r[7:qdbr_pkg::FEAT_RSVD_LSB] != 2'h0);
  assign tag_clash   = (tag_of(num_r) == tag_of(count_r));
  assign tag_invalid = (tag_of(num_r) > max_depth_r) |
                       (tag_of(count_r) > max_depth_r);
  assign dl_ok       = is_deadline & ncq_en_r & ~bad_param &
                       ~tag_clash & ~tag_invalid;

  // ----------------------------------------------------------------
  // command latch
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_code_r <= 8'h00;
      feat_r     <= 8'h00;
      count_r    <= 8'h00;
      num_r      <= 8'h00;
    end else if (cmd_wr) begin
      cmd_code_r <= pwdata_i[qdbr_pkg::CMD_CODE_LSB +: 8];
      feat_r     <= pwdata_i[qdbr_pkg::CMD_FEAT_LSB +: 8];
      count_r    <= pwdata_i[qdbr_pkg::CMD_COUNT_LSB +: 8];
      num_r      <= pwdata_i[qdbr_pkg::CMD_NUM_LSB +: 8];
    end
  end

  // ----------------------------------------------------------------
  // configuration
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ncq_en_r    <= qdbr_pkg::NCQ_EN_RST;
      max_depth_r <= qdbr_pkg::MAX_DEPTH_RST;
    end else if (cfg_wr) begin
      ncq_en_r    <= pwdata_i[qdbr_pkg::CFG_NCQ_EN_BIT];
      max_depth_r <= pwdata_i[qdbr_pkg::CFG_DEPTH_LSB +: qdbr_pkg::TAG_W];
    end
  end

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= qdbr_pkg::ST_IDLE;
      busy_r  <= 1'b0;
      drq_r   <= 1'b0;
      err_r   <= 1'b0;
      abt_r   <= 1'b0;
    end else begin
      case (state_r)
        qdbr_pkg::ST_IDLE: begin
          if (cmd_wr) begin
            state_r <= qdbr_pkg::ST_EXEC;
            busy_r  <= 1'b1;
            err_r   <= 1'b0;
            abt_r   <= 1'b0;
          end
        end
        qdbr_pkg::ST_EXEC: begin
          if (is_rdbuf) begin
            state_r <= qdbr_pkg::ST_XFER;
            busy_r  <= 1'b0;
            drq_r   <= 1'b1;
          end else begin
            state_r <= qdbr_pkg::ST_IDLE;
            busy_r  <= 1'b0;
            err_r   <= ~dl_ok;
            abt_r   <= ~dl_ok;
          end
        end
        qdbr_pkg::ST_XFER: begin
          if (data_pop && rd_ptr_r == AW'(SECTOR_WORDS - 1)) begin
            state_r <= qdbr_pkg::ST_IDLE;
            drq_r   <= 1'b0;
            busy_r  <= 1'b0;
          end
        end
        default: begin
          state_r <= qdbr_pkg::ST_IDLE;
          busy_r  <= 1'b0;
          drq_r   <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // deadline flags and completion notice
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_strict_r <= 1'b0;
      rd_strict_r <= 1'b0;
    end else if (state_r == qdbr_pkg::ST_EXEC && dl_ok) begin
      wr_strict_r <= feat_r[qdbr_pkg::FEAT_WR_STRICT_BIT];
      rd_strict_r <= feat_r[qdbr_pkg::FEAT_RD_STRICT_BIT];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sdb_fis_r <= 1'b0;
      sdb_tag_r <= 5'h00;
    end else begin
      sdb_fis_r <= (state_r == qdbr_pkg::ST_EXEC) & is_qmgmt;
      if (state_r == qdbr_pkg::ST_EXEC && is_qmgmt) begin
        sdb_tag_r <= tag_of(count_r);
      end
    end
  end

  assign sdb_fis_o = sdb_fis_r;
  assign sdb_tag_o = sdb_tag_r;

  // ----------------------------------------------------------------
  // queued completion deadline monitor
  // ----------------------------------------------------------------
  qdbr_deadline_mon u_mon (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i),
    .wr_strict_i (wr_strict_r),
    .rd_strict_i (rd_strict_r),
    .done_i      (qcmd_done_i),
    .is_write_i  (qcmd_is_write_i),
    .priority_class_i      (qcmd_priority_class_i),
    .late_i      (qcmd_late_i),
    .abort_all_o (abort_all)
  );

  assign abort_all_o = abort_all;

  // sticky miss indicator, a new miss wins over a software clear
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      miss_r <= 1'b0;
    end else if (abort_all) begin
      miss_r <= 1'b1;
    end else if (stat_wr && pwdata_i[qdbr_pkg::STAT_MISS]) begin
      miss_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // sector buffer pointers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_r <= '0;
    end else if (cmd_wr) begin
      wr_ptr_r <= '0;
    end else if (data_wr) begin
      wr_ptr_r <= wr_ptr_r + AW'(1);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_ptr_r <= '0;
    end else if (state_r == qdbr_pkg::ST_EXEC) begin
      rd_ptr_r <= '0;
    end else if (data_pop) begin
      rd_ptr_r <= rd_ptr_r + AW'(1);
    end
  end

  // the buffer is shared storage; anything writing it in between may
  // alter the returned sector
  qdbr_sector_buf #(
    .WORDS (SECTOR_WORDS),
    .AW    (AW)
  ) u_buf (
    .sys_clk_i (sys_clk_i),
    .wr_en_i   (data_wr),
    .wr_addr_i (wr_ptr_r),
    .wr_data_i (pwdata_i[15:0]),
    .rd_addr_i (rd_ptr_r),
    .rd_data_o (buf_rd_data)
  );

  // ----------------------------------------------------------------
  // read data, captured in the setup cycle
  // ----------------------------------------------------------------
  logic [7:0] status_byte;
  logic [7:0] error_byte;
  always_comb begin
    status_byte = 8'h00;
    status_byte[qdbr_pkg::STAT_BUSY] = busy_r;
    status_byte[qdbr_pkg::STAT_RDY]  = 1'b1;
    status_byte[qdbr_pkg::STAT_SEEK] = 1'b1;
    status_byte[qdbr_pkg::STAT_DRQ]  = drq_r;
    status_byte[qdbr_pkg::STAT_ERR]  = err_r;
    error_byte = 8'h00;
    error_byte[qdbr_pkg::ERR_ABT]    = abt_r;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_ph && !pwrite_i) begin
      prdata_r <= 32'h0000_0000;
      if (addr_hit(paddr_i, qdbr_pkg::OFF_CMD)) begin
        prdata_r <= {num_r, count_r, feat_r, cmd_code_r};
      end
      if (addr_hit(paddr_i, qdbr_pkg::OFF_CFG)) begin
        prdata_r[qdbr_pkg::CFG_NCQ_EN_BIT]                 <= ncq_en_r;
        prdata_r[qdbr_pkg::CFG_DEPTH_LSB +: qdbr_pkg::TAG_W] <= max_depth_r;
      end
      if (addr_hit(paddr_i, qdbr_pkg::OFF_STAT)) begin
        prdata_r[7:0]                              <= status_byte;
        prdata_r[qdbr_pkg::STAT_ERRREG_LSB +: 8]   <= error_byte;
        prdata_r[qdbr_pkg::STAT_WR_STRICT]         <= wr_strict_r;
        prdata_r[qdbr_pkg::STAT_RD_STRICT]         <= rd_strict_r;
        prdata_r[qdbr_pkg::STAT_MISS]              <= miss_r;
      end
      if (addr_hit(paddr_i, qdbr_pkg::OFF_DATA) && state_r == qdbr_pkg::ST_XFER) begin
        prdata_r[15:0] <= buf_rd_data;
      end
      if (addr_hit(paddr_i, qdbr_pkg::OFF_SDB)) begin
        prdata_r[4:0] <= sdb_tag_r;
      end
    end
  end

  assign prdata_o = prdata_r;

endmodule

`default_nettype wire

//--- testbench/qdbr_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module qdbr_host_model (
  input  wire logic       sys_clk_i,
  output logic            done_o,
  output logic            is_write_o,
  output logic [1:0]      priority_class_o,
  output logic            late_o
);
  initial begin
    done_o = 1'b0;
    is_write_o = 1'b0;
    priority_class_o = 2'h2;
    late_o = 1'b1;
  end

  // ------
  // queued completion event, after an idle gap
  // ------
  // qualifiers only count with done, so they flip once it drops
  task automatic complete(input logic w, input logic [1:0] p, input logic l, input int gap);
    repeat (gap) @(posedge sys_clk_i);
    done_o <= 1'b1;
    is_write_o <= w;
    priority_class_o <= p;
    late_o <= l;
    @(posedge sys_clk_i);
    done_o <= 1'b0;
    is_write_o <= ~w;
    priority_class_o <= ~p;
    late_o <= ~l;
  endtask
endmodule

`default_nettype wire

//--- testbench/qdbr_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module qdbr_top_asserts (
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        qcmd_done_i,
  input wire logic        qcmd_is_write_i,
  input wire logic [1:0]  qcmd_priority_class_i,
  input wire logic        qcmd_late_i,
  input wire logic        sdb_fis_o,
  input wire logic [4:0]  sdb_tag_o,
  input wire logic        abort_all_o
);
  logic       qm_wr;
  logic       late_iso;
  logic [4:0] cmd_tag;

  assign qm_wr = psel_i && penable_i && pwrite_i && paddr_i == qdbr_pkg::OFF_CMD
                 && pwdata_i[7:0] == qdbr_pkg::CMD_QUEUE_MGMT;
  assign late_iso = qcmd_done_i && qcmd_late_i && qcmd_priority_class_i == qdbr_pkg::PRIORITY_CLASS_ISOCH;
  assign cmd_tag = pwdata_i[23:19];

  default clocking dcb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // ------
  // sequences
  // ------
  sequence sdb_once_s;
    sdb_fis_o ##1 !sdb_fis_o;
  endsequence

  sequence quiet_done_s;
    qcmd_done_i && !late_iso;
  endsequence

  // ------
  // assertions
  // ------
  ready_access_a: assert property (psel_i && penable_i |-> pready_o)
    else $error("pready missing in access phase");
  slverr_phase_a: assert property (!(psel_i && penable_i) |-> !pslverr_o)
    else $error("pslverr outside access phase");
  sdb_pulse_a: assert property ($rose(sdb_fis_o) |-> sdb_once_s)
    else $error("sdb notice longer than one cycle");
  sdb_cause_a: assert property (sdb_fis_o |-> $past(qm_wr, 2))
    else $error("sdb notice without queue command two cycles before");
  sdb_tag_a: assert property (sdb_fis_o |-> sdb_tag_o == $past(cmd_tag, 2))
    else $error("sdb tag differs from command tag");
  abort_cause_a: assert property (abort_all_o |-> $past(late_iso))
    else $error("abort all without late isochronous completion");
  ontime_quiet_a: assert property (quiet_done_s |=> !abort_all_o)
    else $error("abort all after a completion that may overrun");
  prdata_hold_a: assert property (!(psel_i && !penable_i) |=> $stable(prdata_o))
    else $error("read data moved without a setup cycle");
endmodule

bind qdbr_top qdbr_top_asserts u_asserts (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .qcmd_done_i(qcmd_done_i),
  .qcmd_is_write_i(qcmd_is_write_i), .qcmd_priority_class_i(qcmd_priority_class_i), .qcmd_late_i(qcmd_late_i),
  .sdb_fis_o(sdb_fis_o), .sdb_tag_o(sdb_tag_o), .abort_all_o(abort_all_o)
);

`default_nettype wire

//--- testbench/qdbr_top_bench.sv
`timescale 1ns/1ps
`default_nettype none

module qdbr_top_bench;
  localparam int LIMIT = 20000;
  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, done, is_wr, late, sdb_fis, abort_all;
  logic [1:0]  priority_class;
  logic [4:0]  sdb_tag;
  logic [31:0] rdat;
  logic        rerr;
  logic        ncq = 1'b1;
  logic [4:0]  depth = 5'h1F;
  logic        wf = 1'b0;
  logic        rf = 1'b0;
  logic [15:0] buf_w [256];
  int          errors, num_checks, sdb_cnt, abt_cnt, cycles;

  qdbr_top u_dut (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .qcmd_done_i(done), .qcmd_is_write_i(is_wr),
    .qcmd_priority_class_i(priority_class), .qcmd_late_i(late), .sdb_fis_o(sdb_fis), .sdb_tag_o(sdb_tag),
    .abort_all_o(abort_all)
  );
  qdbr_host_model u_host (.sys_clk_i(sys_clk), .done_o(done), .is_write_o(is_wr),
    .priority_class_o(priority_class), .late_o(late));

  always #50 sys_clk = ~sys_clk;

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (sdb_fis === 1'b1) sdb_cnt++;
    if (abort_all === 1'b1) abt_cnt++;
    if (cycles == LIMIT) begin
      errors++;
      give_verdict();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ------
  // apb master: setup, access until pready, one idle edge
  // ------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wait_stat(input int b, input logic v);
    int n;
    n = 0;
    rd(qdbr_pkg::OFF_STAT);
    while (rdat[b] !== v && n < 40) begin
      n++;
      rd(qdbr_pkg::OFF_STAT);
    end
  endtask

  function automatic logic [31:0] st_exp(input logic ab, input logic data_request_flag);
    return {16'h0, 5'h00, ab, 2'h0, 4'h5, data_request_flag, 2'h0, ab};
  endfunction

  function automatic logic ab_exp(input logic [7:0] f, input logic [7:0] c, input logic [7:0] s);
    return !ncq || f[3:0] != qdbr_pkg::SUB_DEADLINE || f[7:6] != 2'h0
           || s[7:3] == c[7:3] || s[7:3] > depth || c[7:3] > depth;
  endfunction

  task automatic cfg(input logic n, input logic [4:0] d);
    ncq = n;
    depth = d;
    wr(qdbr_pkg::OFF_CFG, {19'h0, d, 7'h0, n});
    rd(qdbr_pkg::OFF_CFG);
    check("config", {19'h0, d, 7'h0, n}, rdat);
  endtask

  task automatic dl(input logic [7:0] f, input logic [7:0] c, input logic [7:0] s);
    logic ab;
    int   n0;
    ab = ab_exp(f, c, s);
    n0 = sdb_cnt;
    wr(qdbr_pkg::OFF_CMD, {s, c, f, qdbr_pkg::CMD_QUEUE_MGMT});
    wait_stat(qdbr_pkg::STAT_BUSY, 1'b0);
    if (!ab) {rf, wf} = f[5:4];
    check("deadline status", st_exp(ab, 1'b0), {16'h0, rdat[15:0]});
    check("strict flags", {30'h0, rf, wf}, {30'h0, rdat[17:16]});
    check("sdb count", n0 + 1, sdb_cnt);
    check("sdb tag", {27'h0, c[7:3]}, {27'h0, sdb_tag});
    rd(qdbr_pkg::OFF_SDB);
    check("sdb register", {27'h0, c[7:3]}, rdat);
  endtask

  task automatic ev(input logic w, input logic [1:0] p, input logic l);
    int n0;
    n0 = abt_cnt;
    u_host.complete(w, p, l, $urandom % 3);
    repeat (2) @(posedge sys_clk);
    check("abort all", n0 + (l && p == qdbr_pkg::PRIORITY_CLASS_ISOCH && (w ? wf : rf)), abt_cnt);
  endtask

  task automatic mark(input string s);
    $display("test %s finished, checks %0d mismatches %0d", s, num_checks, errors);
  endtask

  initial begin
    void'($urandom(32'h0D8E3A60));
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(qdbr_pkg::OFF_STAT);
    check("status reset", 32'h00000050, rdat);
    rd(qdbr_pkg::OFF_CFG);
    check("config reset", 32'h00001F01, rdat);
    rd(12'h014);
    check("unmapped", 32'h1, {31'h0, rerr});
    mark("reset");
    dl(8'h31, 8'h08, 8'h10);
    dl(8'h01, 8'h08, 8'h08);
    dl(8'h41, 8'h08, 8'h10);
    dl(8'h00, 8'h08, 8'h10);
    cfg(1'b1, 5'h07);
    dl(8'h01, 8'h08, 8'h40);
    dl(8'h21, 8'h08, 8'h38);
    dl(8'h11, 8'h40, 8'h08);
    cfg(1'b0, 5'h1F);
    dl(8'h31, 8'h08, 8'h10);
    for (int i = 0; i < 24; i++) begin
      cfg(i % 5 != 0, 5'($urandom));
      dl({($urandom % 4 == 0) ? 2'h1 : 2'h0, 2'($urandom),
          ($urandom % 3 == 0) ? 4'($urandom) : 4'h1}, 8'($urandom), 8'($urandom));
    end
    mark("deadline decode");
    cfg(1'b1, 5'h1F);
    for (int f = 0; f < 4; f++) begin
      dl({2'h0, 2'(f), 4'h1}, 8'h08, 8'h10);
      for (int k = 0; k < 16; k++) ev(k[3], 2'(k >> 1), k[0]);
      rd(qdbr_pkg::OFF_STAT);
      check("miss flag", {31'h0, f != 0}, {31'h0, rdat[qdbr_pkg::STAT_MISS]});
      wr(qdbr_pkg::OFF_STAT, 32'h01000000);
      rd(qdbr_pkg::OFF_STAT);
      check("miss clear", 32'h0, {31'h0, rdat[qdbr_pkg::STAT_MISS]});
    end
    mark("strict deadline");
    wr(qdbr_pkg::OFF_CMD, 32'h000000C8);
    wait_stat(qdbr_pkg::STAT_BUSY, 1'b0);
    check("other code", st_exp(1'b1, 1'b0), {16'h0, rdat[15:0]});
    for (int i = 0; i < 256; i++) begin
      buf_w[i] = 16'($urandom);
      wr(qdbr_pkg::OFF_DATA, {16'($urandom), buf_w[i]});
    end
    wr(qdbr_pkg::OFF_CMD, {24'h0, qdbr_pkg::CMD_READ_BUFFER});
    wait_stat(qdbr_pkg::STAT_DRQ, 1'b1);
    check("buffer status", st_exp(1'b0, 1'b1), {16'h0, rdat[15:0]});
    for (int i = 0; i < 256; i++) begin
      rd(qdbr_pkg::OFF_DATA);
      check("buffer word", {16'h0, buf_w[i]}, {16'h0, rdat[15:0]});
    end
    rd(qdbr_pkg::OFF_STAT);
    check("sector done", st_exp(1'b0, 1'b0), {16'h0, rdat[15:0]});
    rd(qdbr_pkg::OFF_DATA);
    check("extra word", 32'h0, rdat);
    mark("buffer read");
    give_verdict();
  end
endmodule

`default_nettype wire
